// ### logic/mmtim_defs.svh
// register map, field positions and reset values of the multimode timer unit
`ifndef MMTIM_DEFS_SVH
`define MMTIM_DEFS_SVH

`define MMTIM_OFF_X_MODE 8'h00
`define MMTIM_OFF_Y_MODE 8'h04
`define MMTIM_OFF_T1_MODE 8'h08
`define MMTIM_OFF_X_LOW 8'h0C
`define MMTIM_OFF_X_HIGH 8'h10
`define MMTIM_OFF_Y_LOW 8'h14
`define MMTIM_OFF_Y_HIGH 8'h18
`define MMTIM_OFF_T1 8'h1C
`define MMTIM_OFF_REQ 8'h20
`define MMTIM_OFF_CLK_CTL 8'h24

`define MMTIM_BIT_WRITE_CTL 0
`define MMTIM_BIT_Y_ROUTE 1
`define MMTIM_BIT_MODE_LO 4
`define MMTIM_BIT_MODE_HI 5
`define MMTIM_BIT_POL 6
`define MMTIM_BIT_STOP 7
`define MMTIM_BIT_T1_SEL_T2 0
`define MMTIM_BIT_SMALL_TIMER_OUT_PIN_POL 5
`define MMTIM_BIT_SMALL_TIMER_OUT_PIN_EN 6
`define MMTIM_BIT_T12_WRITE_CTL 7

`define MMTIM_CLK_X_DIV_LO 0
`define MMTIM_CLK_X_DIV_HI 1
`define MMTIM_CLK_Y_DIV_LO 2
`define MMTIM_CLK_Y_DIV_HI 3
`define MMTIM_CLK_X_ALT 4
`define MMTIM_CLK_T1_SUB 5

`define MMTIM_REQ_X 0
`define MMTIM_REQ_Y 1
`define MMTIM_REQ_T1 2
`define MMTIM_REQ_X_PIN 3
`define MMTIM_REQ_Y_PIN 4
`define MMTIM_REQ_W 5

`define MMTIM_RST_MODE 8'h00
`define MMTIM_RST_T16 16'hFFFF
`define MMTIM_RST_T1 8'hFF
`define MMTIM_RST_CLK_CTL 8'h00

`define MMTIM_SYNC_X 0
`define MMTIM_SYNC_Y 1
`define MMTIM_SYNC_ALT 2
`define MMTIM_SYNC_SUB 3

`endif

// ### logic/mmtim_pkg.sv
// types shared by the multimode timer unit
`default_nettype none
package mmtim_pkg;

    typedef enum logic [1:0] {
        MMTIM_MD_TIMER,
        MMTIM_MD_ALT,
        MMTIM_MD_EVENT,
        MMTIM_MD_WIDTH
    } mmtim_mode_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] lat;
        logic [7:0] wr_tmp;
        logic [15:0] rd_tmp;
        logic out;
        logic oe_n;
    } mmtim_t16_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [5:0] pre;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic sub_div;
        logic [7:0] xm;
        logic [7:0] ym;
        logic [7:0] tm;
        logic [7:0] clk_ctl;
        logic [4:0] req;
        mmtim_t16_s tx;
        mmtim_t16_s ty;
        logic [7:0] t1_cnt;
        logic [7:0] t1_lat;
        logic t1_out;
        logic t1_oe_n;
    } mmtim_state_s;

endpackage : mmtim_pkg
`default_nettype wire

// ### logic/mmtim_top.sv
// multimode timer unit: 16-bit timers x and y, 8-bit timer 1, wishbone slave
//
// Behaviour
// - x and y are 16-bit down counters with 16-bit reload latches; timer 1 is 8-bit.
// - count to zero, underflow on next pulse, reload; divide ratio is n plus one.
// - request flags set by events, cleared by writing zero, never set by writing one.
// - each 16-bit timer picks one of four modes from mode bits 5:4.
// - x count stop bit 7 holds timer x in every mode.
// - y count stop bit 7 holds timer y in every mode.
// - x and y count system clock over 8, 16, 32, 64; x may use alternate clock.
// - timer mode underflow sets the request flag, reloads and keeps counting.
// - x pulse output mode inverts x pin on each underflow and sets x flag.
// - x toggle output starts high with polarity zero, low with polarity one.
// - x event mode counts pin edges chosen by polarity; underflow reloads, sets flag.
// - x width mode counts only while pin is at the selected level.
// - x width mode raises x pin request when pin returns to inactive level.
// - y low byte written first to temp; high write loads latch, counter if control zero.
// - x uses same low-then-high write and high-then-low snapshot read scheme.
// - y high byte read snapshots both bytes in timer and event modes; low read returns the snapshot.
// - y timer mode route bit 1 puts toggle on y pin, start level from polarity.
// - y period mode selected edge captures, reloads, raises y pin request.
// - y event mode counts rising edges with polarity zero, falling with one.
// - y width mode captures and reloads on every edge and raises y pin request.
// - timer 1 write control one updates latch only; zero updates both; resets zero.
// - toggle enable drives small timer pin; polarity one starts low, zero high.
// - timer 1 counts clock over 8 or sub clock over 2; underflow flags and reloads.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "mmtim_defs.svh"
`default_nettype none

module mmtim_top
    import mmtim_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input wire logic REF_CLK, // system clock, 250 MHz
    input wire logic RST_N, // asynchronous reset, active low
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // bus strobe
    input wire logic WB_WE_I, // write when high
    input wire logic [ADR_W-1:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // transfer acknowledge
    input wire logic X_COUNTER_PIN_I, // x counter pin level
    output logic X_COUNTER_PIN_O, // x counter pin drive
    output logic X_COUNTER_PIN_OE_N, // low while x pin driven
    input wire logic Y_COUNTER_PIN_I, // y counter pin level
    output logic Y_COUNTER_PIN_O, // y counter pin drive
    output logic Y_COUNTER_PIN_OE_N, // low while y pin driven
    output logic SMALL_TIMER_OUT_PIN_O, // timer 1 toggle output
    output logic SMALL_TIMER_OUT_PIN_OE_N, // low while toggle output enabled
    input wire logic ALT_GENERATED_CLOCK, // alternate count source for x
    input wire logic SUB_CLOCK_INPUT, // sub clock, count source for timer 1
    output logic [4:0] TIMER_REQ // request flags, one per event
);

    if (ADR_W < 8 || ADR_W > 32) begin : g_bad_adr_w
        $error("mmtim_top: ADR_W must lie between 8 and 32");
    end

    mmtim_state_s q;
    mmtim_state_s d;

    // prescaler tap for one of the four divide ratios
    function automatic logic div_tick(input logic [5:0] pre, input logic [1:0] sel);
        logic t;
        t = 1'b0;
        unique case (sel)
            2'h0: t = &pre[2:0];
            2'h1: t = &pre[3:0];
            2'h2: t = &pre[4:0];
            2'h3: t = &pre;
        endcase
        return t;
    endfunction : div_tick

    // one count pulse of a 16-bit timer: {underflow, next count}
    function automatic logic [16:0] step16(input logic [15:0] cnt, input logic [15:0] lat);
        logic [16:0] r;
        r = (cnt == 16'h0000) ? {1'b1, lat} : {1'b0, cnt - 16'h0001};
        return r;
    endfunction : step16

    function automatic logic [8:0] step8(input logic [7:0] cnt, input logic [7:0] lat);
        logic [8:0] r;
        r = (cnt == 8'h00) ? {1'b1, lat} : {1'b0, cnt - 8'h01};
        return r;
    endfunction : step8

    logic hit;
    logic [7:0] a8;
    logic [7:0] wb;
    logic rd;
    logic wr;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [4:0] set;
    logic [4:0] keep;
    mmtim_mode_e xmd;
    mmtim_mode_e ymd;
    logic xpol;
    logic ypol;
    logic xsrc;
    logic ysrc;
    logic xp;
    logic yp;
    logic yedge;
    logic t1p;
    logic [16:0] s16;
    logic [8:0] s8;

    always_comb begin
        d = q;
        set = 5'h00;
        keep = 5'h1F;
        s16 = 17'h00000;
        s8 = 9'h000;

        // bus decode: one wait state, unmapped reads return zero
        a8 = WB_ADR_I[7:0];
        hit = (WB_ADR_I >> 8) == '0;
        wb = WB_DAT_I[7:0];
        rd = WB_CYC_I & WB_STB_I & ~q.ack & ~WB_WE_I;
        wr = WB_CYC_I & WB_STB_I & ~q.ack & WB_WE_I & WB_SEL_I[0] & hit;
        d.ack = WB_CYC_I & WB_STB_I & ~q.ack;
        d.rdat = 32'h00000000;

        // free running system clock prescaler
        d.pre = q.pre + 6'h01;

        // two-stage synchronisers, third stage only for edge detection
        d.s1 = {SUB_CLOCK_INPUT, ALT_GENERATED_CLOCK, Y_COUNTER_PIN_I, X_COUNTER_PIN_I};
        d.s2 = q.s1;
        d.s3 = q.s2;
        rise = q.s2 & ~q.s3;
        fall = ~q.s2 & q.s3;

        xmd = mmtim_mode_e'(q.xm[`MMTIM_BIT_MODE_HI:`MMTIM_BIT_MODE_LO]);
        ymd = mmtim_mode_e'(q.ym[`MMTIM_BIT_MODE_HI:`MMTIM_BIT_MODE_LO]);
        xpol = q.xm[`MMTIM_BIT_POL];
        ypol = q.ym[`MMTIM_BIT_POL];

        // timer x
        xsrc = q.clk_ctl[`MMTIM_CLK_X_ALT] ? rise[`MMTIM_SYNC_ALT]
             : div_tick(q.pre, q.clk_ctl[`MMTIM_CLK_X_DIV_HI:`MMTIM_CLK_X_DIV_LO]);
        xp = 1'b0;
        unique case (xmd)
            MMTIM_MD_TIMER: xp = xsrc;
            MMTIM_MD_ALT: xp = xsrc;
            MMTIM_MD_EVENT: xp = xpol ? fall[`MMTIM_SYNC_X] : rise[`MMTIM_SYNC_X];
            MMTIM_MD_WIDTH: xp = xsrc & (q.s2[`MMTIM_SYNC_X] == ~xpol);
        endcase
        if (xp && !q.xm[`MMTIM_BIT_STOP]) begin
            s16 = step16(q.tx.cnt, q.tx.lat);
            d.tx.cnt = s16[15:0];
            if (s16[16]) begin
                set[`MMTIM_REQ_X] = 1'b1;
                if (xmd == MMTIM_MD_ALT) begin
                    d.tx.out = ~q.tx.out;
                end
            end
        end
        // end of the measured pulse, flagged even while stopped
        if (xmd == MMTIM_MD_WIDTH && (xpol ? rise[`MMTIM_SYNC_X] : fall[`MMTIM_SYNC_X])) begin
            set[`MMTIM_REQ_X_PIN] = 1'b1;
        end
        d.tx.oe_n = (xmd != MMTIM_MD_ALT);

        // timer y
        ysrc = div_tick(q.pre, q.clk_ctl[`MMTIM_CLK_Y_DIV_HI:`MMTIM_CLK_Y_DIV_LO]);
        yp = 1'b0;
        yedge = 1'b0;
        unique case (ymd)
            MMTIM_MD_TIMER: yp = ysrc;
            MMTIM_MD_ALT: begin
                yp = ysrc;
                yedge = ypol ? rise[`MMTIM_SYNC_Y] : fall[`MMTIM_SYNC_Y];
            end
            MMTIM_MD_EVENT: yp = ypol ? fall[`MMTIM_SYNC_Y] : rise[`MMTIM_SYNC_Y];
            MMTIM_MD_WIDTH: begin
                yp = ysrc;
                yedge = rise[`MMTIM_SYNC_Y] | fall[`MMTIM_SYNC_Y];
            end
        endcase
        if (!q.ym[`MMTIM_BIT_STOP]) begin
            // a capture edge wins over a count pulse in the same cycle
            if (yedge) begin
                d.ty.rd_tmp = q.ty.cnt;
                d.ty.cnt = q.ty.lat;
                set[`MMTIM_REQ_Y_PIN] = 1'b1;
            end else if (yp) begin
                s16 = step16(q.ty.cnt, q.ty.lat);
                d.ty.cnt = s16[15:0];
                if (s16[16]) begin
                    set[`MMTIM_REQ_Y] = 1'b1;
                    if (ymd == MMTIM_MD_TIMER) begin
                        d.ty.out = ~q.ty.out;
                    end
                end
            end
        end
        d.ty.oe_n = ~((ymd == MMTIM_MD_TIMER) & q.ym[`MMTIM_BIT_Y_ROUTE]);

        // timer 1: sub clock halved by counting every second rising edge
        if (rise[`MMTIM_SYNC_SUB]) begin
            d.sub_div = ~q.sub_div;
        end
        t1p = q.clk_ctl[`MMTIM_CLK_T1_SUB] ? (rise[`MMTIM_SYNC_SUB] & q.sub_div)
            : div_tick(q.pre, 2'h0);
        if (t1p) begin
            s8 = step8(q.t1_cnt, q.t1_lat);
            d.t1_cnt = s8[7:0];
            if (s8[8]) begin
                set[`MMTIM_REQ_T1] = 1'b1;
                if (q.tm[`MMTIM_BIT_SMALL_TIMER_OUT_PIN_EN] && !q.tm[`MMTIM_BIT_T1_SEL_T2]) begin
                    d.t1_out = ~q.t1_out;
                end
            end
        end
        d.t1_oe_n = ~q.tm[`MMTIM_BIT_SMALL_TIMER_OUT_PIN_EN];

        // register writes come last so they override counting in the same cycle
        if (wr) begin
            unique case (a8)
                `MMTIM_OFF_X_MODE: begin
                    d.xm = wb;
                    d.tx.out = ~wb[`MMTIM_BIT_POL];
                end
                `MMTIM_OFF_Y_MODE: begin
                    d.ym = wb;
                    d.ty.out = ~wb[`MMTIM_BIT_POL];
                end
                `MMTIM_OFF_T1_MODE: begin
                    d.tm = wb;
                    d.t1_out = ~wb[`MMTIM_BIT_SMALL_TIMER_OUT_PIN_POL];
                end
                `MMTIM_OFF_X_LOW: d.tx.wr_tmp = wb;
                `MMTIM_OFF_X_HIGH: begin
                    d.tx.lat = {wb, q.tx.wr_tmp};
                    if (!q.xm[`MMTIM_BIT_WRITE_CTL]) begin
                        d.tx.cnt = {wb, q.tx.wr_tmp};
                    end
                end
                `MMTIM_OFF_Y_LOW: d.ty.wr_tmp = wb;
                `MMTIM_OFF_Y_HIGH: begin
                    d.ty.lat = {wb, q.ty.wr_tmp};
                    if (!q.ym[`MMTIM_BIT_WRITE_CTL]) begin
                        d.ty.cnt = {wb, q.ty.wr_tmp};
                    end
                end
                `MMTIM_OFF_T1: begin
                    d.t1_lat = wb;
                    if (!q.tm[`MMTIM_BIT_T12_WRITE_CTL]) begin
                        d.t1_cnt = wb;
                    end
                end
                `MMTIM_OFF_REQ: keep = wb[4:0];
                `MMTIM_OFF_CLK_CTL: d.clk_ctl = wb;
                default: ;
            endcase
        end

        // a zero written clears, a one leaves the flag; a new event wins
        d.req = (q.req & keep) | set;

        // reads; the high byte read snapshots the live count, for y only in timer and event modes
        if (rd && hit) begin
            unique case (a8)
                `MMTIM_OFF_X_MODE: d.rdat = {24'h000000, q.xm};
                `MMTIM_OFF_Y_MODE: d.rdat = {24'h000000, q.ym};
                `MMTIM_OFF_T1_MODE: d.rdat = {24'h000000, q.tm};
                `MMTIM_OFF_X_LOW: d.rdat = {24'h000000, q.tx.rd_tmp[7:0]};
                `MMTIM_OFF_X_HIGH: begin
                    d.tx.rd_tmp = q.tx.cnt;
                    d.rdat = {24'h000000, q.tx.cnt[15:8]};
                end
                `MMTIM_OFF_Y_LOW: d.rdat = {24'h000000, q.ty.rd_tmp[7:0]};
                `MMTIM_OFF_Y_HIGH: begin
                    // measurement modes keep the edge capture instead of a snapshot
                    if (ymd == MMTIM_MD_TIMER || ymd == MMTIM_MD_EVENT) begin
                        d.ty.rd_tmp = q.ty.cnt;
                        d.rdat = {24'h000000, q.ty.cnt[15:8]};
                    end else begin
                        d.rdat = {24'h000000, q.ty.rd_tmp[15:8]};
                    end
                end
                `MMTIM_OFF_T1: d.rdat = {24'h000000, q.t1_cnt};
                `MMTIM_OFF_REQ: d.rdat = {27'h0000000, q.req};
                `MMTIM_OFF_CLK_CTL: d.rdat = {24'h000000, q.clk_ctl};
                default: d.rdat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q.ack <= 1'b0;
            q.rdat <= 32'h00000000;
            q.pre <= 6'h00;
            q.s1 <= 4'h0;
            q.s2 <= 4'h0;
            q.s3 <= 4'h0;
            q.sub_div <= 1'b0;
            q.xm <= `MMTIM_RST_MODE;
            q.ym <= `MMTIM_RST_MODE;
            q.tm <= `MMTIM_RST_MODE;
            q.clk_ctl <= `MMTIM_RST_CLK_CTL;
            q.req <= 5'h00;
            q.tx.cnt <= `MMTIM_RST_T16;
            q.tx.lat <= `MMTIM_RST_T16;
            q.tx.wr_tmp <= 8'h00;
            q.tx.rd_tmp <= 16'h0000;
            q.tx.out <= 1'b1;
            q.tx.oe_n <= 1'b1;
            q.ty.cnt <= `MMTIM_RST_T16;
            q.ty.lat <= `MMTIM_RST_T16;
            q.ty.wr_tmp <= 8'h00;
            q.ty.rd_tmp <= 16'h0000;
            q.ty.out <= 1'b1;
            q.ty.oe_n <= 1'b1;
            q.t1_cnt <= `MMTIM_RST_T1;
            q.t1_lat <= `MMTIM_RST_T1;
            q.t1_out <= 1'b1;
            q.t1_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign WB_ACK_O = q.ack;
    assign WB_DAT_O = q.rdat;
    assign X_COUNTER_PIN_O = q.tx.out;
    assign X_COUNTER_PIN_OE_N = q.tx.oe_n;
    assign Y_COUNTER_PIN_O = q.ty.out;
    assign Y_COUNTER_PIN_OE_N = q.ty.oe_n;
    assign SMALL_TIMER_OUT_PIN_O = q.t1_out;
    assign SMALL_TIMER_OUT_PIN_OE_N = q.t1_oe_n;
    assign TIMER_REQ = q.req;

endmodule : mmtim_top
`default_nettype wire

// ### verif/mmtim_monitor.sv
// bus and pin checker for the multimode timer unit
`include "mmtim_defs.svh"
`default_nettype none
module mmtim_monitor #(
    parameter int ADR_W = 8
) (
    input wire logic REF_CLK, // clock
    input wire logic RST_N, // reset
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write
    input wire logic [ADR_W-1:0] WB_ADR_I, // address
    input wire logic [3:0] WB_SEL_I, // lanes
    input wire logic [31:0] WB_DAT_I, // write data
    input wire logic [31:0] WB_DAT_O, // read data
    input wire logic WB_ACK_O, // ack
    input wire logic X_COUNTER_PIN_O, // x drive
    input wire logic X_COUNTER_PIN_OE_N, // x enable
    input wire logic Y_COUNTER_PIN_O, // y drive
    input wire logic Y_COUNTER_PIN_OE_N, // y enable
    input wire logic SMALL_TIMER_OUT_PIN_OE_N, // toggle enable
    input wire logic [4:0] TIMER_REQ // flags
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    logic req, wr, wr_flags, unmapped;
    logic [4:0] keep;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = req && WB_WE_I;
    assign wr_flags = wr && WB_SEL_I[0] && WB_ADR_I == ADR_W'(`MMTIM_OFF_REQ);
    assign unmapped = WB_ADR_I[1:0] != 2'h0 || WB_ADR_I > ADR_W'(`MMTIM_OFF_CLK_CTL);
    assign keep = WB_DAT_I[4:0];

    AST_ACK_NEXT: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single pulse after request");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(req))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    AST_DAT_BYTE: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_UNMAPPED: assert property (req && !WB_WE_I && unmapped |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    // a flag may only fall where software wrote a zero
    AST_FLAG_CLEAR: assert property ((|($past(TIMER_REQ) & ~TIMER_REQ)) |->
        $past(wr_flags) && ($past(TIMER_REQ) & ~TIMER_REQ & $past(keep)) == 5'h0)
        else $error("flag cleared without a zero write");
    AST_RESET_STATE: assert property ($rose(RST_N) |-> TIMER_REQ == 5'h00 &&
        X_COUNTER_PIN_OE_N && Y_COUNTER_PIN_OE_N && SMALL_TIMER_OUT_PIN_OE_N)
        else $error("outputs not idle after reset");
    // mode writes reload the start level, so they are excluded
    AST_X_TOGGLE: assert property (!X_COUNTER_PIN_OE_N && $stable(X_COUNTER_PIN_OE_N) &&
        $changed(X_COUNTER_PIN_O) && !$past(wr) && !$past(wr, 2) |-> TIMER_REQ[0])
        else $error("x pin toggled without underflow flag");
    AST_Y_TOGGLE: assert property (!Y_COUNTER_PIN_OE_N && $stable(Y_COUNTER_PIN_OE_N) &&
        $changed(Y_COUNTER_PIN_O) && !$past(wr) && !$past(wr, 2) |-> TIMER_REQ[1])
        else $error("y pin toggled without underflow flag");
endmodule : mmtim_monitor

bind mmtim_top mmtim_monitor #(.ADR_W(ADR_W)) i_mon (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .X_COUNTER_PIN_O(X_COUNTER_PIN_O),
    .X_COUNTER_PIN_OE_N(X_COUNTER_PIN_OE_N), .Y_COUNTER_PIN_O(Y_COUNTER_PIN_O),
    .Y_COUNTER_PIN_OE_N(Y_COUNTER_PIN_OE_N), .TIMER_REQ(TIMER_REQ),
    .SMALL_TIMER_OUT_PIN_OE_N(SMALL_TIMER_OUT_PIN_OE_N)
);
`default_nettype wire

// ### verif/mmtim_pin_model.sv
// external signal sources on the counter pins
`default_nettype none
module mmtim_pin_model (
    input wire logic clk, // system clock
    output logic x_pin, // x pin source
    output logic y_pin, // y pin source
    output logic alt_clk, // alternate source, idle
    output logic sub_clk // sub clock, idle
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        x_pin = 1'b0;
        y_pin = 1'b0;
        alt_clk = 1'b0;
        sub_clk = 1'b0;
    end
    // levels held 4 cycles, well over the 2 the synchroniser needs
    task automatic pulse(input logic [1:0] which, input int n);
        repeat (n) begin
            @(posedge clk);
            x_pin <= which[0];
            y_pin <= which[1];
            repeat (4) @(posedge clk);
            x_pin <= 1'b0;
            y_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulse
endmodule : mmtim_pin_model
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the multimode timer unit
`include "mmtim_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, x_o, x_oe_n, y_o, y_oe_n, t_o, t_oe_n, x_pin, y_pin, alt_clk, sub_clk;
    logic x_line, y_line;
    logic [4:0] req;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    assign x_line = x_oe_n ? x_pin : x_o;
    assign y_line = y_oe_n ? y_pin : y_o;
    always #2 clk = ~clk;

    mmtim_top i_dut (
        .REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .X_COUNTER_PIN_I(x_line), .X_COUNTER_PIN_O(x_o), .X_COUNTER_PIN_OE_N(x_oe_n),
        .Y_COUNTER_PIN_I(y_line), .Y_COUNTER_PIN_O(y_o), .Y_COUNTER_PIN_OE_N(y_oe_n),
        .SMALL_TIMER_OUT_PIN_O(t_o), .SMALL_TIMER_OUT_PIN_OE_N(t_oe_n),
        .ALT_GENERATED_CLOCK(alt_clk), .SUB_CLOCK_INPUT(sub_clk), .TIMER_REQ(req)
    );
    mmtim_pin_model i_pins (
        .clk(clk), .x_pin(x_pin), .y_pin(y_pin), .alt_clk(alt_clk), .sub_clk(sub_clk)
    );

    task automatic tally_and_finish();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            $display("ERROR %0t run too long", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        chk({15'h0, ack}, 16'h0001);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        wb(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask : wr16
    // high byte first: that read takes the snapshot
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a - 8'h04, v[7:0]);
    endtask : rd16
    task automatic wait_flag(input int b, output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req[b] !== 1'b1 && n < 3000);
        t = cycles;
        chk({15'h0, req[b]}, 16'h0001);
    endtask : wait_flag

    task automatic t_reset();
        logic [7:0] q;
        logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h24, 8'h03, 8'hFC};
        chk({13'h0, x_oe_n, y_oe_n, t_oe_n}, 16'h0007);
        foreach (offs[i]) begin
            rd(offs[i], q);
            chk({8'h0, q}, 16'h0000);
        end
    endtask : t_reset

    task automatic t_timer();
        logic [15:0] v;
        logic [7:0] q;
        int t0, t1;
        wr(`MMTIM_OFF_X_MODE, 8'h80);
        wr16(`MMTIM_OFF_X_LOW, 16'h0003);
        rd16(`MMTIM_OFF_X_HIGH, v);
        chk(v, 16'h0003);
        wr(`MMTIM_OFF_X_MODE, 8'h00);
        wait_flag(0, t0);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wait_flag(0, t1);
        chk(16'(t1 - t0), 16'h0020);
        wr(`MMTIM_OFF_CLK_CTL, 8'h01);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wait_flag(0, t0);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wait_flag(0, t1);
        chk(16'(t1 - t0), 16'h0040);
        wr(`MMTIM_OFF_CLK_CTL, 8'h00);
        wr(`MMTIM_OFF_X_MODE, 8'h80);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wr(`MMTIM_OFF_REQ, 8'hFF);
        rd(`MMTIM_OFF_REQ, q);
        chk({15'h0, q[0]}, 16'h0000);
    endtask : t_timer

    task automatic t_wrctl();
        logic [15:0] v;
        wr(`MMTIM_OFF_Y_MODE, 8'h80);
        wr16(`MMTIM_OFF_Y_LOW, 16'h1234);
        rd16(`MMTIM_OFF_Y_HIGH, v);
        chk(v, 16'h1234);
        wr(`MMTIM_OFF_Y_MODE, 8'h81);
        wr16(`MMTIM_OFF_Y_LOW, 16'h5678);
        rd16(`MMTIM_OFF_Y_HIGH, v);
        chk(v, 16'h1234);
    endtask : t_wrctl

    task automatic t_event();
        logic [15:0] v;
        wr(`MMTIM_OFF_X_MODE, 8'h20);
        wr(`MMTIM_OFF_Y_MODE, 8'h20);
        wr16(`MMTIM_OFF_X_LOW, 16'h0005);
        wr16(`MMTIM_OFF_Y_LOW, 16'h0005);
        wr(`MMTIM_OFF_REQ, 8'h00);
        i_pins.pulse(2'b11, 3);
        rd16(`MMTIM_OFF_X_HIGH, v);
        chk(v, 16'h0002);
        rd16(`MMTIM_OFF_Y_HIGH, v);
        chk(v, 16'h0002);
        wr(`MMTIM_OFF_X_MODE, 8'h60);
        wr(`MMTIM_OFF_Y_MODE, 8'h60);
        i_pins.pulse(2'b11, 3);
        rd16(`MMTIM_OFF_X_HIGH, v);
        chk(v, 16'h0005);
        rd16(`MMTIM_OFF_Y_HIGH, v);
        chk(v, 16'h0005);
        chk({14'h0, req[1:0]}, 16'h0003);
    endtask : t_event

    task automatic t_capture();
        logic [15:0] v, w;
        wr(`MMTIM_OFF_Y_MODE, 8'h10);
        wr16(`MMTIM_OFF_Y_LOW, 16'h00FF);
        wr(`MMTIM_OFF_REQ, 8'h00);
        i_pins.pulse(2'b10, 1);
        chk({15'h0, req[4]}, 16'h0001);
        rd16(`MMTIM_OFF_Y_HIGH, v);
        chk({15'h0, v < 16'h00FF}, 16'h0001);
        wr(`MMTIM_OFF_Y_MODE, 8'h30);
        wr(`MMTIM_OFF_REQ, 8'h00);
        i_pins.pulse(2'b10, 1);
        chk({15'h0, req[4]}, 16'h0001);
        wr(`MMTIM_OFF_X_MODE, 8'h30);
        wr16(`MMTIM_OFF_X_LOW, 16'h00FF);
        wr(`MMTIM_OFF_REQ, 8'h00);
        i_pins.pulse(2'b01, 1);
        chk({15'h0, req[3]}, 16'h0001);
        rd16(`MMTIM_OFF_X_HIGH, v);
        repeat (40) @(posedge clk);
        rd16(`MMTIM_OFF_X_HIGH, w);
        chk(w, v);
    endtask : t_capture

    task automatic t_pulse();
        int t0;
        wr(`MMTIM_OFF_X_MODE, 8'h90);
        repeat (2) @(posedge clk);
        chk({14'h0, x_oe_n, x_o}, 16'h0001);
        wr(`MMTIM_OFF_X_MODE, 8'hD0);
        repeat (2) @(posedge clk);
        chk({14'h0, x_oe_n, x_o}, 16'h0000);
        wr16(`MMTIM_OFF_Y_LOW, 16'h0004);
        wr(`MMTIM_OFF_Y_MODE, 8'h02);
        repeat (2) @(posedge clk);
        chk({14'h0, y_oe_n, y_o}, 16'h0001);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wr(`MMTIM_OFF_X_MODE, 8'h50);
        wait_flag(0, t0);
        wait_flag(1, t0);
    endtask : t_pulse

    task automatic t_small();
        logic [7:0] q;
        int t0, t1;
        wr(`MMTIM_OFF_T1, 8'h07);
        rd(`MMTIM_OFF_T1, q);
        chk({15'h0, q == 8'h07 || q == 8'h06}, 16'h0001);
        wr(`MMTIM_OFF_T1_MODE, 8'h80);
        wr(`MMTIM_OFF_T1, 8'h40);
        rd(`MMTIM_OFF_T1, q);
        chk({15'h0, q < 8'h08}, 16'h0001);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wait_flag(2, t0);
        wr(`MMTIM_OFF_REQ, 8'h00);
        wait_flag(2, t1);
        chk(16'(t1 - t0), 16'h0208);
        wr(`MMTIM_OFF_T1_MODE, 8'h00);
        wr(`MMTIM_OFF_T1, 8'hFF);
        wr(`MMTIM_OFF_T1_MODE, 8'h40);
        repeat (2) @(posedge clk);
        chk({14'h0, t_oe_n, t_o}, 16'h0001);
        wr(`MMTIM_OFF_T1_MODE, 8'h60);
        repeat (2) @(posedge clk);
        chk({14'h0, t_oe_n, t_o}, 16'h0000);
    endtask : t_small

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_timer();
        t_wrctl();
        t_event();
        t_capture();
        t_pulse();
        t_small();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
